/* pkg/ldm_regs.vh */
`ifndef LDM_REGS_VH
`define LDM_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LDM_ADDR_CTRL        4'h0
`define LDM_ADDR_GKPER_LO    4'h1
`define LDM_ADDR_GKPER_HI    4'h2
`define LDM_ADDR_RTSTAT      4'h3
`define LDM_ADDR_RAWSTAT     4'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LDM_CTRL_MUXEN_BIT   7
`define LDM_CTRL_POL_BIT     6
`define LDM_CTRL_CLKSRC_BIT  4
`define LDM_CTRL_DBT_MSB     3
`define LDM_CTRL_DBT_LSB     0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LDM_CTRL_RESET       8'h18
`define LDM_GKPER_RESET      8'h00
`define LDM_DBT_RESET        4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LDM_CLK_KHZ          50000
`define LDM_SEL_TICK_KHZ     64
`define LDM_TICK_NS          (1000000 / `LDM_SEL_TICK_KHZ)
`define LDM_SEL_WIDTH_NS     31250
`define LDM_BLANK_NS         15625
`define LDM_SEL_WIDTH_TICKS  (`LDM_SEL_WIDTH_NS / `LDM_TICK_NS)
`define LDM_BLANK_TICKS      (`LDM_BLANK_NS / `LDM_TICK_NS)
`define LDM_SEL_PERIOD_TICKS 13
`define LDM_FRAMES_PER_MS    8
`define LDM_GK_MAX           6

`endif

/* core/ldm_loop_filter.v */
`timescale 1ns/1ps
`include "ldm_regs.vh"

module ldm_loop_filter (
	// Clock and reset
	input  wire       clk,
	input  wire       resetn,
	// Timing strobes
	input  wire       frameTick,
	input  wire       msTick,
	// Data and setting
	input  wire       din,
	input  wire [3:0] dbTime,
	output reg        dout_q
);

	reg       sample_q;
	reg [3:0] count_q;

	// ------------------------------------------------------------
	// Change-reset counter
	// ------------------------------------------------------------
	// counters cleared
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_q <= 1'b0;
			count_q  <= 4'h0;
			dout_q   <= 1'b0;
		end else if (frameTick) begin
			sample_q <= din;
			if (din != sample_q) begin
				count_q <= 4'h0;
			end else begin
				if (msTick && count_q != 4'hF) begin
					count_q <= count_q + 4'h1;
				end
				if (count_q >= dbTime) begin
					dout_q <= sample_q;
				end
			end
		end
	end

endmodule

/* core/ldm_gnd_filter.v */
`timescale 1ns/1ps
`include "ldm_regs.vh"

module ldm_gnd_filter (
	// Clock and reset
	input  wire       clk,
	input  wire       resetn,
	// Timing strobes
	input  wire       frameTick,
	input  wire       msTick,
	// Data and setting
	input  wire       din,
	input  wire [3:0] period,
	output reg        dout_q
);

	reg [3:0] tmr_q;
	reg [2:0] level_q;

	localparam integer GK_MAX = `LDM_GK_MAX;

	// ------------------------------------------------------------
	// Sampling timer and seven-state counter (0 to 6)
	// ------------------------------------------------------------
	// counters cleared
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tmr_q   <= 4'h0;
			level_q <= 3'h0;
			dout_q  <= 1'b0;
		end else if (period == 4'h0) begin
			tmr_q <= 4'h0;
			if (frameTick) begin
				dout_q <= din;
			end
		end else if (msTick) begin
			if (tmr_q + 4'h1 >= period) begin
				tmr_q <= 4'h0;
				if (din && level_q != GK_MAX[2:0]) begin
					level_q <= level_q + 3'h1;
				end else if (!din && level_q != 3'h0) begin
					level_q <= level_q - 3'h1;
				end
				if (din && level_q >= GK_MAX[2:0] - 3'h1) begin
					dout_q <= 1'b1;
				end else if (!din && level_q <= 3'h1) begin
					dout_q <= 1'b0;
				end
			end else begin
				tmr_q <= tmr_q + 4'h1;
			end
		end
	end

endmodule

/* core/ldm_top.v */
// Operation
// - Split detector into loop and ground bits
// - Mux active needs enable and clock-source
// - Select pulse 31.25 us every 13/64 kHz
// - Pin released when mux enable clear
// - Polarity bit sets pulse active level
// - One pulse feeds all channels, times latches
// - Pulse off: loop open, ground holds
// - Pulse on: loop holds, ground open
// - Ignore detector 15.625 us after edges
// - Two filters; ground input selects by mode
// - Shared loop time, own counters
// - Loop filter resets on change, ms count
// - Each channel own ground period
// - Seven-state counter (0 to 6), 1-15 ms period
// - Count up high, down low
// - Set at six, clear at zero
// - Period zero bypasses ground filter
// - No frame sync, no status update
// - Loop debounce resets to 8 ms
// - Reset: mux off, pin released, high-going
`timescale 1ns/1ps
`include "ldm_regs.vh"

module ldm_top #(
	parameter CHANNELS = 4
) (
	// Clock and reset
	input  wire                clk,
	input  wire                resetn,
	// Register port
	input  wire [3:0]          addr,
	input  wire [7:0]          wrData,
	input  wire                wrStrobe,
	input  wire                rdStrobe,
	output reg  [7:0]          rdData_q,
	// Frame sync pin
	input  wire                frameSync,
	// Detector pins from line circuits
	input  wire [CHANNELS-1:0] lineDetectorOutput,
	input  wire [CHANNELS-1:0] secondDetectInput,
	// Shared clock/select pin
	input  wire                sharedClockSelectPinIn,
	output reg                 sharedClockSelectPinOut_q,
	output reg                 sharedClockSelectPinOe_q,
	// Debounced status
	output wire [CHANNELS-1:0] realtimeLoopStatus,
	output wire [CHANNELS-1:0] realtimeGroundStatus
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam integer ACC_MOD  = `LDM_CLK_KHZ;
	localparam integer ACC_STEP = `LDM_SEL_TICK_KHZ;
	localparam integer PH_LAST  = `LDM_SEL_PERIOD_TICKS - 1;
	localparam integer PH_WIDTH = `LDM_SEL_WIDTH_TICKS;
	localparam integer PH_BLANK = `LDM_BLANK_TICKS;
	localparam integer FR_LAST  = `LDM_FRAMES_PER_MS - 1;

	reg  [7:0]          ctrl_q;
	reg  [7:0]          gkPerLo_q;
	reg  [7:0]          gkPerHi_q;
	reg  [15:0]         acc_q;
	reg                 tick_q;
	reg  [3:0]          phase_q;
	reg  [2:0]          fsSync_q;
	reg  [2:0]          frameCnt_q;
	reg                 frameTick_q;
	reg                 msTick_q;
	reg  [CHANNELS-1:0] detMeta_q;
	reg  [CHANNELS-1:0] detSync_q;
	reg  [CHANNELS-1:0] secMeta_q;
	reg  [CHANNELS-1:0] secSync_q;
	reg  [CHANNELS-1:0] loopLatch_q;
	reg  [CHANNELS-1:0] groundLatch_q;
	reg  [7:0]          rdData_d;
	wire [16:0]         accSum;
	wire                muxEnableBit;
	wire                masterClockSourceBit;
	wire                selectPulsePolarity;
	wire [3:0]          loopDebounceTime;
	wire                muxActive;
	wire                detectorSelectPulse;
	wire                blanked;
	wire                loopLatchOpen;
	wire                groundLatchOpen;
	wire [15:0]         groundPeriods;

	// Field extraction from the ground-period word
	function [3:0] ldmNibble;
		input [15:0] word;
		input integer idx;
		begin
			ldmNibble = word[idx*4 +: 4];
		end
	endfunction

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	assign muxEnableBit         = ctrl_q[`LDM_CTRL_MUXEN_BIT];
	assign masterClockSourceBit = ctrl_q[`LDM_CTRL_CLKSRC_BIT];
	assign selectPulsePolarity  = ctrl_q[`LDM_CTRL_POL_BIT];
	assign loopDebounceTime = ctrl_q[`LDM_CTRL_DBT_MSB:`LDM_CTRL_DBT_LSB];
	assign groundPeriods    = {gkPerHi_q, gkPerLo_q};

	assign muxActive = muxEnableBit & masterClockSourceBit;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// debounce reset value
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q    <= `LDM_CTRL_RESET;
			gkPerLo_q <= `LDM_GKPER_RESET;
			gkPerHi_q <= `LDM_GKPER_RESET;
		end else if (wrStrobe) begin
			case (addr)
				`LDM_ADDR_CTRL: begin
					ctrl_q <= wrData;
				end
				`LDM_ADDR_GKPER_LO: begin
					gkPerLo_q <= wrData;
				end
				`LDM_ADDR_GKPER_HI: begin
					gkPerHi_q <= wrData;
				end
				default: begin
					ctrl_q <= ctrl_q;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	// Read mux, unmapped reads zero
	always @* begin
		rdData_d = 8'h00;
		case (addr)
			`LDM_ADDR_CTRL: begin
				rdData_d = ctrl_q;
			end
			`LDM_ADDR_GKPER_LO: begin
				rdData_d = gkPerLo_q;
			end
			`LDM_ADDR_GKPER_HI: begin
				rdData_d = gkPerHi_q;
			end
			`LDM_ADDR_RTSTAT: begin
				rdData_d[3:0] = realtimeLoopStatus;
				rdData_d[7:4] = realtimeGroundStatus;
			end
			`LDM_ADDR_RAWSTAT: begin
				rdData_d[3:0] = loopLatch_q;
				rdData_d[7:4] = groundLatch_q;
			end
			default: begin
				rdData_d = 8'h00;
			end
		endcase
	end

	// Read data valid one cycle after strobe
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= rdStrobe ? rdData_d : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// 64 kHz tick
	// ------------------------------------------------------------
	assign accSum = {1'b0, acc_q} + {1'b0, ACC_STEP[15:0]};

	// Fractional divider, exact on average
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (accSum >= {1'b0, ACC_MOD[15:0]}) begin
			acc_q  <= accSum[15:0] - ACC_MOD[15:0];
			tick_q <= 1'b1;
		end else begin
			acc_q  <= accSum[15:0];
			tick_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Select pulse sequencer
	// ------------------------------------------------------------
	// thirteen-tick period
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= 4'h0;
		end else if (!muxActive) begin
			phase_q <= PH_LAST[3:0];
		end else if (tick_q) begin
			if (phase_q == PH_LAST[3:0]) begin
				phase_q <= 4'h0;
			end else begin
				phase_q <= phase_q + 4'h1;
			end
		end
	end

	assign detectorSelectPulse = muxActive && (phase_q < PH_WIDTH[3:0]);

	assign blanked = muxActive && ((phase_q < PH_BLANK[3:0]) ||
		((phase_q >= PH_WIDTH[3:0]) &&
		(phase_q < PH_WIDTH[3:0] + PH_BLANK[3:0])));

	assign loopLatchOpen   = !detectorSelectPulse && !blanked;
	assign groundLatchOpen = detectorSelectPulse && !blanked;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sharedClockSelectPinOut_q <= 1'b0;
			sharedClockSelectPinOe_q  <= 1'b0;
		end else begin
			sharedClockSelectPinOut_q <=
				detectorSelectPulse ^ selectPulsePolarity;
			sharedClockSelectPinOe_q  <= muxActive;
		end
	end

	// ------------------------------------------------------------
	// Frame sync and millisecond strobe
	// ------------------------------------------------------------
	// Two-stage sync plus edge stage
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fsSync_q <= 3'h0;
		end else begin
			fsSync_q <= {fsSync_q[1:0], frameSync};
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frameCnt_q  <= 3'h0;
			frameTick_q <= 1'b0;
			msTick_q    <= 1'b0;
		end else if (fsSync_q[1] && !fsSync_q[2]) begin
			frameTick_q <= 1'b1;
			msTick_q    <= (frameCnt_q == FR_LAST[2:0]);
			if (frameCnt_q == FR_LAST[2:0]) begin
				frameCnt_q <= 3'h0;
			end else begin
				frameCnt_q <= frameCnt_q + 3'h1;
			end
		end else begin
			frameTick_q <= 1'b0;
			msTick_q    <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Detector input synchronisers
	// ------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			detMeta_q <= {CHANNELS{1'b0}};
			detSync_q <= {CHANNELS{1'b0}};
			secMeta_q <= {CHANNELS{1'b0}};
			secSync_q <= {CHANNELS{1'b0}};
		end else begin
			detMeta_q <= lineDetectorOutput;
			detSync_q <= detMeta_q;
			secMeta_q <= secondDetectInput;
			secSync_q <= secMeta_q;
		end
	end

	// ------------------------------------------------------------
	// Per-channel demux latches and filters
	// ------------------------------------------------------------
	// pulse-timed demux latches
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			loopLatch_q   <= {CHANNELS{1'b0}};
			groundLatch_q <= {CHANNELS{1'b0}};
		end else begin
			if (loopLatchOpen) begin
				loopLatch_q <= detSync_q;
			end
			if (groundLatchOpen) begin
				groundLatch_q <= detSync_q;
			end
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
			wire groundIn;
			assign groundIn = muxActive ? groundLatch_q[ch]
				: secSync_q[ch];

			ldm_loop_filter uLoop (
				.clk       (clk),
				.resetn    (resetn),
				.frameTick (frameTick_q),
				.msTick    (msTick_q),
				.din       (loopLatch_q[ch]),
				.dbTime    (loopDebounceTime),
				.dout_q    (realtimeLoopStatus[ch])
			);

			ldm_gnd_filter uGnd (
				.clk       (clk),
				.resetn    (resetn),
				.frameTick (frameTick_q),
				.msTick    (msTick_q),
				.din       (groundIn),
				.period    (ldmNibble(groundPeriods, ch)),
				.dout_q    (realtimeGroundStatus[ch])
			);
		end
	endgenerate

endmodule

/* testbench/ldm_slic_model.sv */
`timescale 1ns/1ps

module ldm_slic_model (
	// Clock
	input  wire       clk,
	// Select pin level and circuit polarity
	input  wire       pinLevel,
	input  wire       polHigh,
	// Detector states per channel
	input  wire [3:0] loopState,
	input  wire [3:0] gndState,
	output wire [3:0] line_detector_output
);
	logic [3:0] det_q = 4'h0;
	logic       selPrev_q = 1'b0;
	logic [8:0] settle_q = 9'h000;
	wire        sel = (pinLevel == polHigh);

	assign line_detector_output = det_q;

	// one pulse, all channels
	// Detector toggles until settled after a switch
	always @(posedge clk) begin
		selPrev_q <= sel;
		if (sel != selPrev_q)
			settle_q <= 9'h0FA;
		else if (settle_q != 9'h000)
			settle_q <= settle_q - 9'h001;
		if (settle_q != 9'h000)
			det_q <= ~det_q;
		else
			det_q <= sel ? gndState : loopState;
	end
endmodule

/* testbench/ldm_top_asserts.sv */
`timescale 1ns/1ps

module ldm_top_chk #(
	parameter CHANNELS = 4
) (
	// Clock and reset
	input wire                clk,
	input wire                resetn,
	// Register port
	input wire [3:0]          addr,
	input wire [7:0]          wrData,
	input wire                wrStrobe,
	input wire                rdStrobe,
	input wire [7:0]          rdData_q,
	// Pins
	input wire                frameSync,
	input wire [CHANNELS-1:0] lineDetectorOutput,
	input wire [CHANNELS-1:0] secondDetectInput,
	input wire                sharedClockSelectPinIn,
	input wire                sharedClockSelectPinOut_q,
	input wire                sharedClockSelectPinOe_q,
	input wire [CHANNELS-1:0] realtimeLoopStatus,
	input wire [CHANNELS-1:0] realtimeGroundStatus
);
	logic [7:0]  ctrl_q;
	logic [15:0] wid_q;
	logic [15:0] per_q;
	logic [9:0]  fs_q;
	logic        on_q;
	logic        seen_q;
	logic        fsPrev_q;
	wire         oe = sharedClockSelectPinOe_q;
	wire         act = ctrl_q[7] & ctrl_q[4];
	wire         selOn = oe & (sharedClockSelectPinOut_q ^ ctrl_q[6]);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Shadow control, pulse widths, time since frame
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= 8'h18;
			wid_q <= 16'h0000;
			per_q <= 16'h0000;
			fs_q <= 10'h000;
			on_q <= 1'b0;
			seen_q <= 1'b0;
			fsPrev_q <= 1'b0;
		end else begin
			if (wrStrobe && addr == 4'h0)
				ctrl_q <= wrData;
			on_q <= selOn;
			wid_q <= selOn ? wid_q + 16'h0001 : 16'h0000;
			per_q <= (selOn && !on_q) ? 16'h0001 : per_q + 16'h0001;
			seen_q <= oe && (seen_q || (selOn && !on_q));
			fsPrev_q <= frameSync;
			if (frameSync && !fsPrev_q)
				fs_q <= 10'h000;
			else if (fs_q != 10'h3FF)
				fs_q <= fs_q + 10'h001;
		end
	end

	property p_oe_on;
		$rose(act) |-> ##[1:3] oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("select pin not driven in mux mode");
	property p_oe_off;
		!act [*3] |-> !oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("select pin driven outside mux mode");
	property p_rst_quiet;
		$rose(resetn) |-> !oe && realtimeLoopStatus == 0
			&& realtimeGroundStatus == 0;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs not cleared by reset");
	property p_width;
		on_q && !selOn && oe |-> wid_q >= 16'h0619 && wid_q <= 16'h061C;
	endproperty
	a_width: assert property (p_width)
		else $error("select pulse width wrong");
	property p_period;
		selOn && !on_q && seen_q |-> per_q >= 16'h27AB && per_q <= 16'h27AE;
	endproperty
	a_period: assert property (p_period)
		else $error("select pulse period wrong");
	property p_pol_idle;
		$rose(oe) |-> sharedClockSelectPinOut_q == ctrl_q[6];
	endproperty
	a_pol_idle: assert property (p_pol_idle)
		else $error("select idle level wrong");
	property p_noframe;
		$changed({realtimeGroundStatus, realtimeLoopStatus}) |-> fs_q < 10'h00A;
	endproperty
	a_noframe: assert property (p_noframe)
		else $error("status changed without frame");
	property p_rd_ctrl;
		rdStrobe && addr == 4'h0 |=> rdData_q == $past(ctrl_q);
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl)
		else $error("control readback wrong");
endmodule

bind ldm_top ldm_top_chk #(.CHANNELS(CHANNELS)) ldm_top_chk_i (
	.clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData),
	.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData_q(rdData_q),
	.frameSync(frameSync), .lineDetectorOutput(lineDetectorOutput),
	.secondDetectInput(secondDetectInput),
	.sharedClockSelectPinIn(sharedClockSelectPinIn),
	.sharedClockSelectPinOut_q(sharedClockSelectPinOut_q),
	.sharedClockSelectPinOe_q(sharedClockSelectPinOe_q),
	.realtimeLoopStatus(realtimeLoopStatus),
	.realtimeGroundStatus(realtimeGroundStatus));

/* testbench/testbench.sv */
`timescale 1ns/1ps

module testbench;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic       wrStrobe = 1'b0;
	logic       rdStrobe = 1'b0;
	logic       frameSync = 1'b0;
	logic       fsOn = 1'b1;
	logic       polHigh = 1'b1;
	logic [3:0] second = 4'h0;
	logic [3:0] loopState = 4'h0;
	logic [3:0] gndState = 4'h0;
	wire  [7:0] rdData_q;
	wire  [3:0] line_detector_output;
	wire  [3:0] rtLoop;
	wire  [3:0] rtGnd;
	wire        pinOut;
	wire        pinOe;
	wire        pinLevel = pinOe ? pinOut : 1'b0;
	int         failures = 0;
	int         checked = 0;

	// Clock, and frames every 40 cycles to keep the run short
	always #10 clk = ~clk;
	always begin
		repeat (20) @(posedge clk);
		frameSync <= fsOn & ~frameSync;
	end

	ldm_top ldm_top_i (.clk(clk), .resetn(resetn), .addr(addr),
		.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.rdData_q(rdData_q), .frameSync(frameSync),
		.lineDetectorOutput(line_detector_output), .secondDetectInput(second),
		.sharedClockSelectPinIn(pinLevel),
		.sharedClockSelectPinOut_q(pinOut),
		.sharedClockSelectPinOe_q(pinOe),
		.realtimeLoopStatus(rtLoop), .realtimeGroundStatus(rtGnd));
	ldm_slic_model ldm_slic_model_i (.clk(clk), .pinLevel(pinLevel),
		.polHigh(polHigh), .loopState(loopState), .gndState(gndState),
		.line_detector_output(line_detector_output));

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		@(negedge clk);
		chk(rdData_q, e);
	endtask
	task automatic fr(input int n);
		repeat (n * 40) @(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		int n;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		rd(4'h0, 8'h18);
		rd(4'h3, 8'h00);
		wr(4'h3, 8'hFF);
		rd(4'h3, 8'h00);
		rd(4'hF, 8'h00);
		chk({7'h0, pinOe}, 8'h00);
		$display("reset test done");
		wr(4'h0, 8'h14);
		second <= 4'hA;
		loopState <= 4'h5;
		fr(20);
		chk({rtGnd, rtLoop}, 8'hA0);
		fr(20);
		chk({4'h0, rtLoop}, 8'h05);
		fsOn <= 1'b0;
		repeat (25) @(posedge clk); // Let a frame in flight pass
		second <= 4'h5;
		repeat (300) @(posedge clk);
		chk({4'h0, rtGnd}, 8'h0A);
		fsOn <= 1'b1;
		fr(3);
		chk({4'h0, rtGnd}, 8'h05);
		$display("bypass and loop test done");
		second <= 4'h0;
		fr(3);
		wr(4'h1, 8'h41);
		second <= 4'hF;
		fr(32);
		chk({4'h0, rtGnd}, 8'h0C);
		fr(32);
		chk({4'h0, rtGnd}, 8'h0D);
		second <= 4'hE;
		fr(24);
		chk({4'h0, rtGnd}, 8'h0D);
		fr(48);
		chk({4'h0, rtGnd}, 8'h0C);
		$display("ground filter test done");
		wr(4'h1, 8'h00);
		loopState <= 4'h6;
		gndState <= 4'hC;
		wr(4'h0, 8'h94);
		repeat (3) @(posedge clk);
		chk({7'h0, pinOe}, 8'h01);
		repeat (25000) @(posedge clk);
		for (n = 0; n < 12000 && !pinLevel; n++)
			@(posedge clk);
		repeat (100) @(posedge clk);
		rd(4'h4, 8'hC6);
		chk({rtGnd, rtLoop}, 8'hC6);
		wr(4'h0, 8'h14);
		repeat (3) @(posedge clk);
		chk({7'h0, pinOe}, 8'h00);
		$display("mux test done");
		polHigh <= 1'b0;
		gndState <= 4'h3;
		wr(4'h0, 8'hD4);
		repeat (25000) @(posedge clk);
		rd(4'h4, 8'h36);
		wr(4'h0, 8'hC4);
		repeat (3) @(posedge clk);
		chk({7'h0, pinOe}, 8'h00);
		$display("polarity test done");
		summarize();
	end

	// Watchdog
	initial begin
		repeat (95000) @(posedge clk);
		failures++;
		summarize();
	end
endmodule
